// >>> inc/lcp_map.svh
`ifndef LCP_MAP_SVH
`define LCP_MAP_SVH

// ------------------------------------------------------------
// Channel geometry
// ------------------------------------------------------------
`define LCP_NCH 4
`define LCP_CNT_W 27
`define LCP_CNT_MAX 27'h7FFFFFF

// ------------------------------------------------------------
// AHB word offsets, decoded on haddr[3:0], haddr[31:4] zero
// ------------------------------------------------------------
`define LCP_A_INDEX 4'h0
`define LCP_A_DATA 4'h4
`define LCP_A_ADDR 4'h8
`define LCP_A_FLAGS 4'hC

// ------------------------------------------------------------
// Byte index space reached through the data window
// ------------------------------------------------------------
`define LCP_IX_CTRL 8'h02
`define LCP_IX_ADDR 8'h03
`define LCP_IX_CH0 8'h04
`define LCP_CH_STRIDE 8'h05
`define LCP_OFF_STATUS 3'h0

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define LCP_ST_READY 0
`define LCP_ST_OVF 1
`define LCP_ST_RESET 2
`define LCP_CTRL_ADDR_SEL 4
`define LCP_CTRL_RST 8'h00
`define LCP_ADDR_DEF 7'h10
`define LCP_ADDR_ALT 7'h11
`define LCP_FLAGS_STANDBY 16

`endif

// >>> inc/lcp_pkg.sv
`include "lcp_map.svh"
`default_nettype none

package lcp_pkg;

   typedef enum logic [0:0]
   {
      LCP_BUS_IDLE = 1'b0,
      LCP_BUS_WAIT = 1'b1
   } lcp_bus_state_t;

   typedef logic [`LCP_CNT_W-1:0] lcp_count_t;

   // Returns {hit, channel[1:0], byte offset[2:0]} for a byte index
   function automatic logic [5:0] lcp_byte_sel(input logic [7:0] idx);
      logic [5:0] res;
      logic [7:0] base;
      res = 6'h00;
      base = 8'h00;
      for (int c = 0; c < `LCP_NCH; c++)
      begin
         base = 8'(`LCP_IX_CH0 + c * `LCP_CH_STRIDE);
         if ((idx >= base) && (idx < 8'(base + `LCP_CH_STRIDE)))
         begin
            res = {1'b1, 2'(c), 3'(idx - base)};
         end
      end
      return res;
   endfunction : lcp_byte_sel

endpackage : lcp_pkg

`default_nettype wire

// >>> verilog/lcp_period_ctr.sv
`include "lcp_map.svh"
`default_nettype none

module lcp_period_ctr
(
   // Oscillator clock and reset
   input wire logic osc_clk,
   input wire logic hresetn,
   // Converter input and run gate
   input wire logic freq_pin,
   input wire logic run,
   // Handshake towards the bus domain
   input wire logic ack_tgl,
   output logic req_tgl,
   output lcp_pkg::lcp_count_t hold_count,
   output logic hold_ovf
);

   logic f1_q, f2_q, f3_q;
   logic a1_q, a2_q;
   logic rise, busy, take, at_max;
   lcp_pkg::lcp_count_t cnt_q;
   logic ovf_run_q, armed_q;

   // ------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge osc_clk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         f1_q <= 1'b0;
         f2_q <= 1'b0;
         f3_q <= 1'b0;
         a1_q <= 1'b0;
         a2_q <= 1'b0;
      end
      else
      begin
         f1_q <= freq_pin;
         f2_q <= f1_q;
         f3_q <= f2_q;
         a1_q <= ack_tgl;
         a2_q <= a1_q;
      end
   end

   assign rise = f2_q & ~f3_q;
   assign busy = req_tgl ^ a2_q;
   assign at_max = (cnt_q == `LCP_CNT_MAX);
   // First edge after wake only starts a period; a result still in flight is kept
   assign take = run & rise & armed_q & ~busy;

   // ------------------------------------------------------------
   // Period counter
   // ------------------------------------------------------------
   always_ff @(posedge osc_clk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_q <= '0;
         ovf_run_q <= 1'b0;
         armed_q <= 1'b0;
      end
      else if (!run)
      begin
         cnt_q <= '0;
         ovf_run_q <= 1'b0;
         armed_q <= 1'b0;
      end
      else if (rise)
      begin
         cnt_q <= '0;
         ovf_run_q <= 1'b0;
         armed_q <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q + 27'h0000001;
         if (at_max)
         begin
            ovf_run_q <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Result hold, stable until the bus domain acknowledges
   // ------------------------------------------------------------
   always_ff @(posedge osc_clk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hold_count <= '0;
         hold_ovf <= 1'b0;
         req_tgl <= 1'b0;
      end
      else if (take)
      begin
         hold_count <= cnt_q;
         hold_ovf <= ovf_run_q;
         req_tgl <= ~req_tgl;
      end
   end

   wrap_overflow_a: assert property (@(posedge osc_clk) disable iff (!hresetn)
      (run && !rise && at_max) |=> (ovf_run_q && (cnt_q == '0)))
      else $error("counter wrap not flagged");

   edge_restart_a: assert property (@(posedge osc_clk) disable iff (!hresetn)
      (run && rise) |=> (cnt_q == '0) ##1 (!run || rise || (cnt_q == 27'h0000001)))
      else $error("counter did not restart on edge");

   hold_capture_a: assert property (@(posedge osc_clk) disable iff (!hresetn)
      take |=> ((hold_count == $past(cnt_q)) && (req_tgl != $past(req_tgl))))
      else $error("period not captured");

endmodule : lcp_period_ctr

`default_nettype wire

// >>> verilog/lcp_readout.sv
// Contract
// - Four light channels, each measured independently
// - 27-bit free-running counter on oscillator clock
// - Each channel shows reset, overflow, ready, count
// - Reset flag set on reset or wake
// - Status read clears the reset flag
// - Overflow flag set when counter wrapped
// - Overflow cleared only by new valid count
// - Ready set on new count, cleared by status read
// - Count right-aligned, four bytes, MSB first
// - Strap low selects 0x10, high 0x11
// - Standby while sleep pin low
// - Byte index auto-increments per byte
// - Address-select write samples strap, updates address
//
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`include "lcp_map.svh"
`default_nettype none

module lcp_readout
(
   // Bus clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Oscillator domain
   input wire logic osc_clk,
   input wire logic [3:0] light_to_freq_converter,
   // Device pins
   input wire logic sleep_control_pin,
   input wire logic mp_pin_i,
   output logic mp_pin_o,
   output logic mp_pin_oe,
   // Status towards the serial slave
   output logic [6:0] dev_addr,
   output logic standby
);

   lcp_pkg::lcp_bus_state_t bus_state_q;
   logic [3:0] addr_q;
   logic wr_q, hit_q;
   logic take, acc, rd_data, wr_data, wr_index, wr_ctrl;
   logic [7:0] idx_q, ctrl_q, byte_rd;
   logic [5:0] sel;
   logic sel_hit;
   logic [1:0] sel_ch;
   logic [2:0] sel_off;
   logic [31:0] rd_word;
   logic [3:0] st_rd;

   logic sleep_s1_q, sleep_s2_q, sleep_s3_q, resume;
   logic run_s1_q, run_s2_q;
   logic strap_s1_q, strap_s2_q;
   logic [3:0] req_tgl, req_s1_q, req_s2_q, req_s3_q, new_evt;
   logic [3:0] hold_ovf, rdy_q, ovf_q, rst_flag_q;
   lcp_pkg::lcp_count_t hold_cnt [`LCP_NCH];
   lcp_pkg::lcp_count_t live_q [`LCP_NCH];
   lcp_pkg::lcp_count_t snap_q [`LCP_NCH];

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sleep_s1_q <= 1'b0;
         sleep_s2_q <= 1'b0;
         sleep_s3_q <= 1'b0;
         strap_s1_q <= 1'b0;
         strap_s2_q <= 1'b0;
      end
      else
      begin
         sleep_s1_q <= sleep_control_pin;
         sleep_s2_q <= sleep_s1_q;
         sleep_s3_q <= sleep_s2_q;
         strap_s1_q <= mp_pin_i;
         strap_s2_q <= strap_s1_q;
      end
   end

   // Sleep level reaches the counters through their own two flops
   always_ff @(posedge osc_clk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         run_s1_q <= 1'b0;
         run_s2_q <= 1'b0;
      end
      else
      begin
         run_s1_q <= sleep_control_pin;
         run_s2_q <= run_s1_q;
      end
   end

   assign resume = sleep_s2_q & ~sleep_s3_q;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         standby <= 1'b1;
      end
      else
      begin
         standby <= ~sleep_s2_q;
      end
   end

   // The comparator and PWM driver live elsewhere; the pin is left to its strap resistor
   assign mp_pin_o = 1'b0;
   assign mp_pin_oe = 1'b0;

   // ------------------------------------------------------------
   // Channel counters on the oscillator clock
   // ------------------------------------------------------------
   for (genvar g = 0; g < `LCP_NCH; g++)
   begin : g_ch
      lcp_period_ctr u_ctr
      (
         .osc_clk(osc_clk),
         .hresetn(hresetn),
         .freq_pin(light_to_freq_converter[g]),
         .run(run_s2_q),
         .ack_tgl(req_s3_q[g]),
         .req_tgl(req_tgl[g]),
         .hold_count(hold_cnt[g]),
         .hold_ovf(hold_ovf[g])
      );

      ready_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
         new_evt[g] |=> rdy_q[g])
         else $error("ready not set on new count");

      status_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
         (st_rd[g] && !new_evt[g] && !resume) |=> (!rdy_q[g] && !rst_flag_q[g]))
         else $error("status read did not clear flags");

      overflow_track_a: assert property (@(posedge hclk) disable iff (!hresetn)
         new_evt[g] |=> (ovf_q[g] == $past(hold_ovf[g]))
         ##1 (new_evt[g] || ovf_q[g] == $past(ovf_q[g])))
         else $error("overflow flag wrong");

      snap_consistent_a: assert property (@(posedge hclk) disable iff (!hresetn)
         st_rd[g] |=> (snap_q[g] == $past(live_q[g])))
         else $error("snapshot not taken at status read");

      count_msb_a: assert property (@(posedge hclk) disable iff (!hresetn)
         (rd_data && sel_hit && (sel_ch == 2'(g)) && (sel_off == 3'h1))
         |=> (hrdata == {29'h00000000, snap_q[g][26:24]}))
         else $error("count msb byte wrong");
   end

   // ------------------------------------------------------------
   // Crossing of results into the bus domain
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         req_s1_q <= 4'h0;
         req_s2_q <= 4'h0;
         req_s3_q <= 4'h0;
      end
      else
      begin
         req_s1_q <= req_tgl;
         req_s2_q <= req_s1_q;
         req_s3_q <= req_s2_q;
      end
   end

   // Hold data stay put until the echoed toggle returns, so one pulse per result
   assign new_evt = req_s2_q ^ req_s3_q;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int c = 0; c < `LCP_NCH; c++)
         begin
            live_q[c] <= '0;
         end
      end
      else
      begin
         for (int c = 0; c < `LCP_NCH; c++)
         begin
            if (new_evt[c])
            begin
               live_q[c] <= hold_cnt[c];
            end
         end
      end
   end

   // Status read freezes the count so the next four bytes belong together
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int c = 0; c < `LCP_NCH; c++)
         begin
            snap_q[c] <= '0;
         end
      end
      else
      begin
         for (int c = 0; c < `LCP_NCH; c++)
         begin
            if (st_rd[c])
            begin
               snap_q[c] <= live_q[c];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Channel flags; a new count beats a same-cycle clear
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rst_flag_q <= 4'hF;
      end
      else if (resume)
      begin
         rst_flag_q <= 4'hF;
      end
      else
      begin
         rst_flag_q <= rst_flag_q & ~st_rd;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rdy_q <= 4'h0;
      end
      else
      begin
         rdy_q <= (rdy_q & ~st_rd) | new_evt;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ovf_q <= 4'h0;
      end
      else
      begin
         ovf_q <= (ovf_q & ~new_evt) | (hold_ovf & new_evt);
      end
   end

   // ------------------------------------------------------------
   // AHB-Lite slave, one wait state per transfer
   // ------------------------------------------------------------
   assign take = hsel & htrans[1] & hready & (bus_state_q == lcp_pkg::LCP_BUS_IDLE);
   assign hreadyout = (bus_state_q != lcp_pkg::LCP_BUS_WAIT);
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         bus_state_q <= lcp_pkg::LCP_BUS_IDLE;
         addr_q <= 4'h0;
         wr_q <= 1'b0;
         hit_q <= 1'b0;
      end
      else
      begin
         case (bus_state_q)
            lcp_pkg::LCP_BUS_IDLE:
            begin
               if (take)
               begin
                  bus_state_q <= lcp_pkg::LCP_BUS_WAIT;
                  addr_q <= haddr[3:0];
                  wr_q <= hwrite;
                  hit_q <= (haddr[31:4] == 28'h0000000) && (haddr[1:0] == 2'h0);
               end
            end
            lcp_pkg::LCP_BUS_WAIT:
            begin
               bus_state_q <= lcp_pkg::LCP_BUS_IDLE;
            end
            default:
            begin
               bus_state_q <= lcp_pkg::LCP_BUS_IDLE;
            end
         endcase
      end
   end

   assign acc = (bus_state_q == lcp_pkg::LCP_BUS_WAIT) & hit_q;
   assign rd_data = acc & ~wr_q & (addr_q == `LCP_A_DATA);
   assign wr_data = acc & wr_q & (addr_q == `LCP_A_DATA);
   assign wr_index = acc & wr_q & (addr_q == `LCP_A_INDEX);
   assign wr_ctrl = wr_data & (idx_q == `LCP_IX_CTRL);

   assign sel = lcp_pkg::lcp_byte_sel(idx_q);
   assign sel_hit = sel[5];
   assign sel_ch = sel[4:3];
   assign sel_off = sel[2:0];

   always_comb
   begin
      for (int c = 0; c < `LCP_NCH; c++)
      begin
         st_rd[c] = rd_data & sel_hit & (sel_ch == 2'(c)) & (sel_off == `LCP_OFF_STATUS);
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         idx_q <= 8'h00;
      end
      else if (wr_index)
      begin
         idx_q <= hwdata[7:0];
      end
      else if (rd_data | wr_data)
      begin
         idx_q <= idx_q + 8'h01;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_q <= `LCP_CTRL_RST;
      end
      else if (wr_ctrl)
      begin
         ctrl_q <= hwdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dev_addr <= `LCP_ADDR_DEF;
      end
      else if (resume)
      begin
         dev_addr <= `LCP_ADDR_DEF;
      end
      else if (wr_ctrl && hwdata[`LCP_CTRL_ADDR_SEL])
      begin
         dev_addr <= strap_s2_q ? `LCP_ADDR_ALT : `LCP_ADDR_DEF;
      end
   end

   // Byte window: status then count bytes, most significant first
   always_comb
   begin
      byte_rd = 8'h00;
      if (sel_hit)
      begin
         case (sel_off)
            3'h0:
            begin
               byte_rd[`LCP_ST_READY] = rdy_q[sel_ch];
               byte_rd[`LCP_ST_OVF] = ovf_q[sel_ch];
               byte_rd[`LCP_ST_RESET] = rst_flag_q[sel_ch];
            end
            3'h1: byte_rd = {5'h00, snap_q[sel_ch][26:24]};
            3'h2: byte_rd = snap_q[sel_ch][23:16];
            3'h3: byte_rd = snap_q[sel_ch][15:8];
            3'h4: byte_rd = snap_q[sel_ch][7:0];
            default: byte_rd = 8'h00;
         endcase
      end
      else if (idx_q == `LCP_IX_CTRL)
      begin
         byte_rd = ctrl_q;
      end
      else if (idx_q == `LCP_IX_ADDR)
      begin
         byte_rd = {1'b0, dev_addr};
      end
   end

   always_comb
   begin
      rd_word = 32'h00000000;
      case (addr_q)
         `LCP_A_INDEX: rd_word = {24'h000000, idx_q};
         `LCP_A_DATA: rd_word = {24'h000000, byte_rd};
         `LCP_A_ADDR: rd_word = {25'h0000000, dev_addr};
         `LCP_A_FLAGS:
         begin
            rd_word[3:0] = rdy_q;
            rd_word[7:4] = ovf_q;
            rd_word[11:8] = rst_flag_q;
            rd_word[`LCP_FLAGS_STANDBY] = standby;
         end
         default: rd_word = 32'h00000000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata <= 32'h00000000;
      end
      else if (bus_state_q == lcp_pkg::LCP_BUS_WAIT)
      begin
         hrdata <= (hit_q && !wr_q) ? rd_word : 32'h00000000;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   bus_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
      take |=> !hreadyout ##1 hreadyout)
      else $error("bus wait state wrong");

   index_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_data || wr_data) |=> (idx_q == ($past(idx_q) + 8'h01)))
      else $error("index did not advance");

   resume_flags_a: assert property (@(posedge hclk) disable iff (!hresetn)
      resume |=> ((rst_flag_q == 4'hF) && (dev_addr == `LCP_ADDR_DEF)))
      else $error("wake did not set reset flags");

   strap_addr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_ctrl && hwdata[`LCP_CTRL_ADDR_SEL] && !resume)
      |=> (dev_addr == ($past(strap_s2_q) ? `LCP_ADDR_ALT : `LCP_ADDR_DEF)))
      else $error("address not taken from strap");

   standby_shown_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (!sleep_s2_q ##1 !sleep_s2_q) |-> standby)
      else $error("standby not shown while asleep");

endmodule : lcp_readout

`default_nettype wire

// >>> verification/lcp_freq_src.sv
`default_nettype none

module lcp_freq_src
(
   // Oscillator clock
   input wire logic osc_clk,
   // Period of channel 0 in oscillator cycles
   input wire logic [15:0] base,
   // Converter outputs
   output logic [3:0] freq
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] cnt_q [4];

   // ----------------------------------------
   // Period generators
   // ----------------------------------------
   // Each channel has its own period, so a swapped channel shows up in its count
   initial
   begin
      freq = 4'h0;
      cnt_q = '{default: 16'h0000};
   end
   always @(posedge osc_clk)
   begin
      for (int c = 0; c < 4; c++)
      begin
         cnt_q[c] <= (cnt_q[c] >= base + 16'(c * 64) - 16'h0001) ? 16'h0000 :
            cnt_q[c] + 16'h0001;
         freq[c] <= (cnt_q[c] < 16'h0008);
      end
   end
endmodule : lcp_freq_src

`default_nettype wire

// >>> verification/test_light_channel_period_readout.sv
`include "lcp_map.svh"
`default_nettype none

module test_light_channel_period_readout;
   timeunit 1ns;
   timeprecision 100ps;
   logic hclk, hresetn, hsel, hwrite, osc_clk, sleep_control_pin, strap;
   logic hreadyout, hresp, standby, dp_rd;
   logic [31:0] haddr, hwdata, hrdata, e, m, seed, v, p;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [6:0] dev_addr;
   logic [3:0] freq;
   logic [31:0] exp_q [$];
   logic [31:0] msk_q [$];
   int n_fail, n_checks;

   // ----------------------------------------
   // Clocks and instances
   // ----------------------------------------
   initial
   begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   initial
   begin
      osc_clk = 1'b0;
      #7;
      forever #16 osc_clk = ~osc_clk;
   end

   lcp_readout i_lcp_readout
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .osc_clk(osc_clk),
      .light_to_freq_converter(freq), .sleep_control_pin(sleep_control_pin),
      .mp_pin_i(strap), .mp_pin_o(), .mp_pin_oe(), .dev_addr(dev_addr), .standby(standby)
   );
   lcp_freq_src i_lcp_freq_src (.osc_clk(osc_clk), .base(16'h0052), .freq(freq));

   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   // Read data is taken at the edge that ends the data phase
   always @(posedge hclk)
   begin
      if (dp_rd && hreadyout === 1'b1)
      begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         check(hrdata & m, e);
      end
      if (hreadyout === 1'b1)
         dp_rd = hsel && htrans[1] && !hwrite;
   end

   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask : xfer

   task automatic rd(input logic [31:0] a, input logic [31:0] x, input logic [31:0] k);
      exp_q.push_back(x & k);
      msk_q.push_back(k);
      xfer(a, 1'b0, 32'h0000_0000);
   endtask : rd

   // Status read of one channel; the burst always starts here
   task automatic stat(input int c, input logic [31:0] x, input logic [31:0] k);
      xfer(32'(`LCP_A_INDEX), 1'b1, 32'(`LCP_IX_CH0 + c * `LCP_CH_STRIDE));
      rd(32'(`LCP_A_DATA), x, k);
   endtask : stat

   task automatic sel_addr(input logic s, input logic [31:0] x);
      strap <= s;
      repeat (4) @(posedge hclk);
      xfer(32'(`LCP_A_INDEX), 1'b1, 32'(`LCP_IX_CTRL));
      xfer(32'(`LCP_A_DATA), 1'b1, 32'h0000_0010);
      rd(32'(`LCP_A_DATA), x, 32'h0000_00FF);
      check(32'(dev_addr), x);
   endtask : sel_addr

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      seed = 32'h06D3;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      sleep_control_pin = 1'b1;
      strap = 1'b0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (6) @(posedge hclk);
      rd(32'(`LCP_A_FLAGS), 32'h0000_0F00, 32'h0001_0FFF);
      rd(32'(`LCP_A_ADDR), 32'h0000_0010, 32'h0000_007F);
      repeat (4)
      begin
         v = 32'($random(seed)) & 32'h0000_00FF;
         xfer(32'(`LCP_A_INDEX), 1'b1, v);
         rd(32'(`LCP_A_INDEX), v, 32'hFFFF_FFFF);
      end
      rd(32'h0000_0010, 32'h0000_0000, 32'hFFFF_FFFF);
      $display("test reset and registers done");
      // Long enough for at least two periods on the slowest channel
      repeat (1500) @(posedge hclk);
      rd(32'(`LCP_A_FLAGS), 32'h0000_0F0F, 32'h0000_0FFF);
      for (int c = 0; c < 4; c++)
      begin
         p = 32'h0000_0052 + 32'(c) * 32'h0000_0040;
         // Five-byte burst; the low two count bits absorb edge jitter
         stat(c, 32'h0000_0005, 32'hFFFF_FFFF);
         rd(32'(`LCP_A_DATA), 32'h0000_0000, 32'hFFFF_FFFF);
         rd(32'(`LCP_A_DATA), 32'h0000_0000, 32'hFFFF_FFFF);
         rd(32'(`LCP_A_DATA), p >> 8, 32'hFFFF_FFFF);
         rd(32'(`LCP_A_DATA), p & 32'h0000_00FF, 32'hFFFF_FFFC);
      end
      rd(32'(`LCP_A_FLAGS), 32'h0000_0000, 32'h0000_0F00);
      $display("test channel readout done");
      sel_addr(1'b1, 32'h0000_0011);
      sel_addr(1'b0, 32'h0000_0010);
      sel_addr(1'b1, 32'h0000_0011);
      $display("test address strap done");
      sleep_control_pin <= 1'b0;
      repeat (10) @(posedge hclk);
      rd(32'(`LCP_A_FLAGS), 32'h0001_0000, 32'h0001_0F00);
      check(32'(standby), 32'h0000_0001);
      for (int c = 0; c < 4; c++)
      begin
         stat(c, 32'h0000_0000, 32'h0000_0006);
         stat(c, 32'h0000_0000, 32'h0000_0007);
      end
      sleep_control_pin <= 1'b1;
      repeat (10) @(posedge hclk);
      check(32'(standby), 32'h0000_0000);
      rd(32'(`LCP_A_FLAGS), 32'h0000_0F00, 32'h0001_0F00);
      rd(32'(`LCP_A_ADDR), 32'h0000_0010, 32'h0000_007F);
      stat(2, 32'h0000_0004, 32'h0000_0006);
      $display("test standby and wake done");
      repeat (4) @(posedge hclk);
      report_and_stop;
   end

   // Whole run is about 1800 bus cycles; this cuts a hang short
   initial
   begin
      #200us;
      n_fail++;
      report_and_stop;
   end
endmodule : test_light_channel_period_readout

`default_nettype wire
